// >>> bprf_regfile.sv
// Mode-banked program register file with status words and program counter.
`timescale 1ns/1ps
`default_nettype none
module bprf_regfile (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [2:0]  mode,
  input  wire logic        compact_state,
  input  wire logic [3:0]  rd_a_idx,
  input  wire logic        rd_a_pc_zero,
  input  wire logic [3:0]  rd_b_idx,
  input  wire logic        rd_b_pc_zero,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [1:0]  wr_pc_kind,
  input  wire logic        link_en,
  input  wire logic [31:0] link_addr,
  input  wire logic        pc_adv_en,
  input  wire logic [31:0] pc_adv,
  input  wire logic        status_wr_en,
  input  wire logic [31:0] status_wr_data,
  input  wire logic        saved_wr_en,
  input  wire logic [31:0] saved_wr_data,
  input  wire logic        exc_en,
  input  wire logic [2:0]  exc_mode,
  input  wire logic [31:0] exc_link,
  input  wire logic [31:0] exc_status,
  output logic      [31:0] rd_a_data,
  output logic      [31:0] rd_b_data,
  output logic      [31:0] pc,
  output logic             branch_taken,
  output logic      [31:0] current_status_word,
  output logic      [31:0] saved_status_word,
  output logic             saved_valid
);

  // Whole state: 31 general slots, one current and five saved status words, and the registered read, branch and saved-view outputs.
  typedef struct packed {
    logic [bprf_pkg::GP_REGS-1:0][31:0]    gp;
    logic [31:0]                           cur;
    logic [bprf_pkg::SAVED_REGS-1:0][31:0] sav;
    logic [31:0]                           rda;
    logic [31:0]                           rdb;
    logic                                  brt;
    logic [31:0]                           savo;
    logic                                  savv;
  } bprf_state_t;

  bprf_state_t st;
  bprf_state_t next_st;

  logic [2:0] bank;
  logic [2:0] bank_a;
  logic [2:0] bank_b;
  logic [4:0] wr_phys;
  logic [4:0] a_phys;
  logic [4:0] b_phys;
  logic [4:0] lnk_phys;
  logic [4:0] exc_phys;
  logic [2:0] exc_bank;
  logic       priv;
  logic       exc_priv;
  logic       unused_banks;

  // Separate mapper copies per port keep every access in the same cycle.
  bprf_bank_map u_map_wr (
    .mode      (mode),
    .arch_idx  (wr_idx),
    .bank      (bank),
    .phys_idx  (wr_phys),
    .has_saved (priv)
  );
  bprf_bank_map u_map_a (
    .mode      (mode),
    .arch_idx  (rd_a_idx),
    .bank      (bank_a),
    .phys_idx  (a_phys),
    .has_saved ()
  );
  bprf_bank_map u_map_b (
    .mode      (mode),
    .arch_idx  (rd_b_idx),
    .bank      (bank_b),
    .phys_idx  (b_phys),
    .has_saved ()
  );
  bprf_bank_map u_map_lnk (
    .mode      (mode),
    .arch_idx  (bprf_pkg::REG_LINK),
    .bank      (),
    .phys_idx  (lnk_phys),
    .has_saved ()
  );
  bprf_bank_map u_map_exc (
    .mode      (exc_mode),
    .arch_idx  (bprf_pkg::REG_LINK),
    .bank      (exc_bank),
    .phys_idx  (exc_phys),
    .has_saved (exc_priv)
  );
  assign unused_banks = ^{bank_a, bank_b};

  // Program counter read value for the current instruction state.
  function automatic logic [31:0] pc_view(input logic [31:0] cur_pc,
                                          input logic        cmp,
                                          input logic        zero);
    logic [31:0] v;
    v = cur_pc + (cmp ? bprf_pkg::PC_OFS_COMPACT
                      : bprf_pkg::PC_OFS_WIDE);
    if (zero) begin
      v = bprf_pkg::ZERO_WORD;
    end
    return v;
  endfunction

  // Alignment mask applied to any value that lands in the program counter.
  function automatic logic [31:0] align_pc(input logic [31:0] v,
                                           input logic        cmp);
    return v & (cmp ? bprf_pkg::HALF_ALIGN
                    : bprf_pkg::WORD_ALIGN);
  endfunction

  // Saved status index for a bank; user bank has none.
  function automatic logic [2:0] sav_idx(input logic [2:0] b);
    return 3'(b - 3'h1);
  endfunction

  // Next-state logic. Reads sample before the write of the same cycle.
  // Compact-state high register restrictions are left to the decoder;
  // the file offers every index so the variants reach 8 to 15.
  always_comb begin
    next_st = st;
    next_st.brt = 1'b0;
    // Reads of general and banked slots; 15 gives the offset view.
    next_st.rda = (rd_a_idx == bprf_pkg::REG_PC)
      ? pc_view(st.gp[bprf_pkg::SLOT_PC], compact_state, rd_a_pc_zero)
      : st.gp[a_phys];
    next_st.rdb = (rd_b_idx == bprf_pkg::REG_PC)
      ? pc_view(st.gp[bprf_pkg::SLOT_PC], compact_state, rd_b_pc_zero)
      : st.gp[b_phys];
    // Sequential advance of the program counter.
    if (pc_adv_en) begin
      next_st.gp[bprf_pkg::SLOT_PC] = align_pc(pc_adv, compact_state);
    end
    // General write; registers 0 to 14 just store what arrives.
    if (wr_en && wr_idx != bprf_pkg::REG_PC) begin
      next_st.gp[wr_phys] = wr_data;
    end else if (wr_en) begin
      unique case (bprf_pkg::bprf_pcw_t'(wr_pc_kind))
        bprf_pkg::PCW_BRANCH: begin
          next_st.gp[bprf_pkg::SLOT_PC] =
            align_pc(wr_data, compact_state);
          next_st.brt = 1'b1;
        end
        bprf_pkg::PCW_FLAGS: begin
          next_st.cur[bprf_pkg::FLAGS_HI:bprf_pkg::FLAGS_LO] =
            wr_data[bprf_pkg::FLAGS_HI:bprf_pkg::FLAGS_LO];
        end
        default: begin
          next_st.brt = 1'b0;
        end
      endcase
    end
    // Link write for branch with link in the current mode's bank.
    if (link_en) begin
      next_st.gp[lnk_phys] = link_addr;
    end
    // Software access to the status words.
    if (status_wr_en) begin
      next_st.cur = status_wr_data;
    end
    if (saved_wr_en && priv) begin
      next_st.sav[sav_idx(bank)] = saved_wr_data;
    end
    // Exception entry wins: link and saved status of the target mode,
    // and the new current status, all in one edge.
    if (exc_en && exc_priv) begin
      next_st.gp[exc_phys] = exc_link;
      // Indexed by the mapped bank, so a new mode code cannot misfile it.
      next_st.sav[sav_idx(exc_bank)] = st.cur;
      next_st.cur = exc_status;
    end
    // Saved status view, only in exception modes.
    next_st.savv = priv;
    next_st.savo = priv ? next_st.sav[sav_idx(bank)]
                        : bprf_pkg::ZERO_WORD;
  end

  // Single register stage for all state, reset to constants only.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.cur <= bprf_pkg::RESET_STATUS;
    end else begin
      st <= next_st;
    end
  end

  assign rd_a_data           = st.rda;
  assign rd_b_data           = st.rdb;
  assign pc                  = st.gp[bprf_pkg::SLOT_PC];
  assign branch_taken        = st.brt;
  assign current_status_word = st.cur;
  assign saved_status_word   = st.savo;
  assign saved_valid         = st.savv;

  // A branch write to 15 lands aligned on the next edge.
  pc_branch_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    wr_en && wr_idx == bprf_pkg::REG_PC && !exc_en && !pc_adv_en &&
    wr_pc_kind == 2'(bprf_pkg::PCW_BRANCH)
    |=> branch_taken && pc == align_pc($past(wr_data), $past(compact_state)))
    else $error("program counter branch write lost");

  // A discarded write leaves the program counter alone.
  pc_discard_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    wr_en && wr_idx == bprf_pkg::REG_PC && !pc_adv_en &&
    wr_pc_kind == 2'(bprf_pkg::PCW_DISCARD)
    |=> $stable(pc) && !branch_taken)
    else $error("discarded program counter write changed it");

  // Flags-only write moves bits 31..28 and nothing else.
  pc_flags_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    wr_en && wr_idx == bprf_pkg::REG_PC && !status_wr_en && !exc_en &&
    wr_pc_kind == 2'(bprf_pkg::PCW_FLAGS)
    |=> current_status_word[31:28] == $past(wr_data[31:28]) &&
        current_status_word[27:0] == $past(current_status_word[27:0]) &&
        !branch_taken)
    else $error("flag update from 15 wrong");

  // Read of 15 shows address plus 8 or 4.
  pc_read_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    rd_a_idx == bprf_pkg::REG_PC && !rd_a_pc_zero
    |=> rd_a_data == $past(pc) +
        ($past(compact_state) ? bprf_pkg::PC_OFS_COMPACT
                              : bprf_pkg::PC_OFS_WIDE))
    else $error("program counter read offset wrong");

  // Zero form of a read of 15.
  pc_zero_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    rd_b_idx == bprf_pkg::REG_PC && rd_b_pc_zero
    |=> rd_b_data == bprf_pkg::ZERO_WORD)
    else $error("zero read of 15 not zero");

  // Program counter is word aligned after an advance in the wide state.
  pc_align_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    pc_adv_en && !compact_state |=> pc[1:0] == 2'h0)
    else $error("program counter misaligned");

  // Saved status visible only outside user and system modes.
  saved_view_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (mode == 3'(bprf_pkg::MODE_USER) || mode == 3'(bprf_pkg::MODE_SYSTEM))
    |=> !saved_valid && saved_status_word == bprf_pkg::ZERO_WORD)
    else $error("saved status visible in user bank");

  // Exception entry saves old status and sets the new one together.
  exc_entry_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    exc_en && exc_mode == 3'(bprf_pkg::MODE_SVC)
    |=> current_status_word == $past(exc_status) &&
        st.sav[sav_idx(3'(bprf_pkg::BANK_SVC))] ==
          $past(current_status_word) &&
        st.gp[bprf_pkg::SLOT_SVC_SP + 5'h1] == $past(exc_link))
    else $error("exception entry incomplete");

  // Fast interrupt register 8 is not the shared register 8.
  fiq_bank_a: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    wr_en && wr_idx == bprf_pkg::REG_FIQ_LO &&
    mode == 3'(bprf_pkg::MODE_FIQ) && !exc_en
    |=> st.gp[bprf_pkg::REG_FIQ_LO] == $past(st.gp[bprf_pkg::REG_FIQ_LO]) &&
        st.gp[bprf_pkg::SLOT_FIQ_BASE] == $past(wr_data))
    else $error("fast interrupt bank not private");

endmodule
`default_nettype wire

// >>> bprf_pkg.sv
// Package with constants and types for the banked program register file.
package bprf_pkg;

  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ARCH_REGS    = 16;
  localparam int unsigned GP_REGS      = 31;
  localparam int unsigned STATUS_REGS  = 6;
  localparam int unsigned PHYS_REGS    = GP_REGS + STATUS_REGS;
  localparam int unsigned SAVED_REGS   = 5;
  localparam int unsigned PHYS_IDX_W   = 5;

  // Physical slots of the general register store.
  localparam logic [4:0] SLOT_FIQ_BASE = 5'h10;
  localparam logic [4:0] SLOT_SVC_SP   = 5'h17;
  localparam logic [4:0] SLOT_ABT_SP   = 5'h19;
  localparam logic [4:0] SLOT_IRQ_SP   = 5'h1B;
  localparam logic [4:0] SLOT_UND_SP   = 5'h1D;
  localparam logic [4:0] SLOT_PC       = 5'h0F;

  // Architectural register numbers with a special role.
  localparam logic [3:0] REG_SP        = 4'hD;
  localparam logic [3:0] REG_LINK      = 4'hE;
  localparam logic [3:0] REG_PC        = 4'hF;
  localparam logic [3:0] REG_FIQ_LO    = 4'h8;

  // Program counter read offsets and alignment.
  localparam logic [31:0] PC_OFS_WIDE    = 32'h0000_0008;
  localparam logic [31:0] PC_OFS_COMPACT = 32'h0000_0004;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
  localparam logic [31:0] WORD_ALIGN     = 32'hFFFF_FFFC;
  localparam logic [31:0] HALF_ALIGN     = 32'hFFFF_FFFE;

  // Status word fields.
  localparam int unsigned FLAGS_HI     = 31;
  localparam int unsigned FLAGS_LO     = 28;
  localparam logic [31:0] RESET_STATUS = 32'h0000_00D3;
  localparam logic [31:0] RESET_PC     = 32'h0000_0000;

  // Bank identifiers derived from the operating mode.
  typedef enum logic [2:0] {
    BANK_USR = 3'h0,
    BANK_FIQ = 3'h1,
    BANK_IRQ = 3'h2,
    BANK_SVC = 3'h3,
    BANK_ABT = 3'h4,
    BANK_UND = 3'h5
  } bprf_bank_t;

  // Operating mode, one code per mode; the pipeline owns the encoding.
  typedef enum logic [2:0] {
    MODE_USER   = 3'h0,
    MODE_FIQ    = 3'h1,
    MODE_IRQ    = 3'h2,
    MODE_SVC    = 3'h3,
    MODE_ABT    = 3'h4,
    MODE_UND    = 3'h5,
    MODE_SYSTEM = 3'h6
  } bprf_mode_t;

  // How a write to the program counter is treated.
  typedef enum logic [1:0] {
    PCW_BRANCH  = 2'h0,
    PCW_DISCARD = 2'h1,
    PCW_FLAGS   = 2'h2
  } bprf_pcw_t;

  // How a read of the program counter is answered.
  typedef enum logic [0:0] {
    PCR_ADDR = 1'h0,
    PCR_ZERO = 1'h1
  } bprf_pcr_t;

endpackage

// >>> bprf_bank_map.sv
// Mode to bank and architectural to physical register mapping.
`timescale 1ns/1ps
`default_nettype none
module bprf_bank_map (
  input  wire logic [2:0] mode,
  input  wire logic [3:0] arch_idx,
  output var  logic [2:0] bank,
  output var  logic [4:0] phys_idx,
  output var  logic       has_saved
);

  // Banking follows the mode only; instruction state never enters here.
  always_comb begin
    unique case (bprf_pkg::bprf_mode_t'(mode))
      bprf_pkg::MODE_FIQ: bank = 3'(bprf_pkg::BANK_FIQ);
      bprf_pkg::MODE_IRQ: bank = 3'(bprf_pkg::BANK_IRQ);
      bprf_pkg::MODE_SVC: bank = 3'(bprf_pkg::BANK_SVC);
      bprf_pkg::MODE_ABT: bank = 3'(bprf_pkg::BANK_ABT);
      bprf_pkg::MODE_UND: bank = 3'(bprf_pkg::BANK_UND);
      default:            bank = 3'(bprf_pkg::BANK_USR);
    endcase
    has_saved = (bank != 3'(bprf_pkg::BANK_USR));
    phys_idx = {1'b0, arch_idx};
    if (bank == 3'(bprf_pkg::BANK_FIQ) &&
        arch_idx >= bprf_pkg::REG_FIQ_LO &&
        arch_idx < bprf_pkg::REG_PC) begin
      phys_idx = bprf_pkg::SLOT_FIQ_BASE
               + 5'(arch_idx - bprf_pkg::REG_FIQ_LO);
    end else if (arch_idx == bprf_pkg::REG_SP ||
                 arch_idx == bprf_pkg::REG_LINK) begin
      unique case (bprf_pkg::bprf_bank_t'(bank))
        bprf_pkg::BANK_SVC:
          phys_idx = bprf_pkg::SLOT_SVC_SP + 5'(arch_idx[0] ^ 1'b1);
        bprf_pkg::BANK_ABT:
          phys_idx = bprf_pkg::SLOT_ABT_SP + 5'(arch_idx[0] ^ 1'b1);
        bprf_pkg::BANK_IRQ:
          phys_idx = bprf_pkg::SLOT_IRQ_SP + 5'(arch_idx[0] ^ 1'b1);
        bprf_pkg::BANK_UND:
          phys_idx = bprf_pkg::SLOT_UND_SP + 5'(arch_idx[0] ^ 1'b1);
        default: phys_idx = {1'b0, arch_idx};
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> bprf_pipe_model.sv
// Pipeline-side model that drives the banked register file inputs.
`timescale 1ns/1ps
`default_nettype none
module bprf_pipe_model (
  input  wire logic        core_clk,
  input  wire logic [31:0] rd_a_data,
  input  wire logic [31:0] rd_b_data,
  output logic      [2:0]  mode,
  output logic             compact_state,
  output logic      [3:0]  rd_a_idx,
  output logic             rd_a_pc_zero,
  output logic      [3:0]  rd_b_idx,
  output logic             rd_b_pc_zero,
  output logic             wr_en,
  output logic      [3:0]  wr_idx,
  output logic      [31:0] wr_data,
  output logic      [1:0]  wr_pc_kind,
  output logic             link_en,
  output logic      [31:0] link_addr,
  output logic             pc_adv_en,
  output logic      [31:0] pc_adv,
  output logic             status_wr_en,
  output logic      [31:0] status_wr_data,
  output logic             saved_wr_en,
  output logic      [31:0] saved_wr_data,
  output logic             exc_en,
  output logic      [2:0]  exc_mode,
  output logic      [31:0] exc_link,
  output logic      [31:0] exc_status
);
  // Idle at time zero: user mode, wide state, no strobes.
  initial begin
    {mode, compact_state, rd_a_idx, rd_a_pc_zero, rd_b_idx} = '0;
    {rd_b_pc_zero, wr_en, wr_idx, wr_pc_kind, link_en, pc_adv_en} = '0;
    {status_wr_en, saved_wr_en, exc_en, exc_mode} = '0;
    {wr_data, link_addr, pc_adv, status_wr_data} = '0;
    {saved_wr_data, exc_link, exc_status} = '0;
  end

  // Mode is a level owned by the pipeline; one edge lets the views follow.
  task automatic set_mode(input logic [2:0] m, input logic cs);
    @(posedge core_clk);
    mode          <= m;
    compact_state <= cs;
    @(posedge core_clk);
    #1;
  endtask

  // One-cycle strobe set s = {wr, exc, link, adv, status, saved}.
  // Released data lines carry the inverse, so stale words never pass.
  task automatic op(input logic [5:0] s, input logic [3:0] i,
                    input logic [1:0] k, input logic [31:0] d);
    @(posedge core_clk);
    {wr_en, exc_en, link_en, pc_adv_en, status_wr_en, saved_wr_en} <= s;
    {wr_idx, exc_mode, wr_pc_kind} <= {i, i[2:0], k};
    {wr_data, link_addr, pc_adv} <= {3{d}};
    {status_wr_data, saved_wr_data, exc_link, exc_status} <= {4{d}};
    @(posedge core_clk);
    {wr_en, exc_en, link_en, pc_adv_en, status_wr_en, saved_wr_en} <= 6'h00;
    {wr_data, link_addr, pc_adv} <= {3{~d}};
    {status_wr_data, saved_wr_data, exc_link, exc_status} <= {4{~d}};
    #1;
  endtask

  // Both read ports are sampled at the next edge and answer after it.
  task automatic rd(input logic [3:0] ia, ib, input logic za, zb,
                    output logic [31:0] da, db);
    @(posedge core_clk);
    {rd_a_idx, rd_b_idx, rd_a_pc_zero, rd_b_pc_zero} <= {ia, ib, za, zb};
    @(posedge core_clk);
    #1;
    da = rd_a_data;
    db = rd_b_data;
  endtask
endmodule
`default_nettype wire

// >>> tb_banked_program_register_file.sv
// Self-checking bench for the banked program register file.
`timescale 1ns/1ps
`default_nettype none
module tb_banked_program_register_file;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  mode, exc_mode;
  logic [3:0]  rd_a_idx, rd_b_idx, wr_idx;
  logic [1:0]  wr_pc_kind;
  logic        compact_state, rd_a_pc_zero, rd_b_pc_zero, wr_en, link_en;
  logic        pc_adv_en, status_wr_en, saved_wr_en, exc_en;
  logic        branch_taken, saved_valid;
  logic [31:0] wr_data, link_addr, pc_adv, status_wr_data, saved_wr_data;
  logic [31:0] exc_link, exc_status, rd_a_data, rd_b_data, pc;
  logic [31:0] current_status_word, saved_status_word, da, db;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // Clock at 40 MHz.
  always #12.5 core_clk = ~core_clk;

  // The pipeline model drives every request input of the register file.
  bprf_pipe_model bprf_pipe_model_i (
    .core_clk, .rd_a_data, .rd_b_data, .mode, .compact_state, .rd_a_idx,
    .rd_a_pc_zero, .rd_b_idx, .rd_b_pc_zero, .wr_en, .wr_idx, .wr_data,
    .wr_pc_kind, .link_en, .link_addr, .pc_adv_en, .pc_adv, .status_wr_en,
    .status_wr_data, .saved_wr_en, .saved_wr_data, .exc_en, .exc_mode,
    .exc_link, .exc_status
  );

  bprf_regfile bprf_regfile_i (
    .core_clk, .arst_n, .mode, .compact_state, .rd_a_idx, .rd_a_pc_zero,
    .rd_b_idx, .rd_b_pc_zero, .wr_en, .wr_idx, .wr_data, .wr_pc_kind,
    .link_en, .link_addr, .pc_adv_en, .pc_adv, .status_wr_en,
    .status_wr_data, .saved_wr_en, .saved_wr_data, .exc_en, .exc_mode,
    .exc_link, .exc_status, .rd_a_data, .rd_b_data, .pc, .branch_taken,
    .current_status_word, .saved_status_word, .saved_valid
  );

  // Short forms of the model's operations.
  task automatic md(input logic [2:0] m, input logic cs);
    bprf_pipe_model_i.set_mode(m, cs);
  endtask
  task automatic op(input logic [5:0] s, input logic [3:0] i,
                    input logic [1:0] k, input logic [31:0] d);
    bprf_pipe_model_i.op(s, i, k, d);
  endtask
  task automatic w(input logic [3:0] i, input logic [31:0] d);
    op(6'h20, i, 2'h0, d);
  endtask
  task automatic r(input logic [3:0] a, b, input logic za, zb);
    bprf_pipe_model_i.rd(a, b, za, zb, da, db);
  endtask

  // Four-state compare; an unknown never counts as a match.
  task automatic check(input string n, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", n, exp, got);
      bad_count++;
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The scenarios need well under a thousand cycles; a hang is cut here.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic t_reset();
    check("rst_status", current_status_word,
          bprf_pkg::RESET_STATUS);
    check("rst_pc", pc, bprf_pkg::RESET_PC);
    check("rst_valid", 32'(saved_valid), 32'h0);
  endtask

  // Fast-interrupt mode banks 8 to 14 while low registers stay shared.
  task automatic t_fiq();
    for (int i = 8; i < 15; i++) begin
      w(4'(i), 32'hA000_0000 | 32'(i));
    end
    md(bprf_pkg::MODE_FIQ, 1'b0);
    for (int i = 8; i < 15; i++) begin
      w(4'(i), 32'hB000_0000 | 32'(i));
    end
    w(4'h3, 32'h0000_00C3);
    md(bprf_pkg::MODE_USER, 1'b0);
    for (int i = 8; i < 15; i++) begin
      r(4'(i), 4'h3, 1'b0, 1'b0);
      check("usr_bank", da, 32'hA000_0000 | 32'(i));
      check("shared_low", db, 32'h0000_00C3);
    end
    md(bprf_pkg::MODE_FIQ, 1'b0);
    for (int i = 8; i < 15; i++) begin
      r(4'(i), 4'h3, 1'b0, 1'b0);
      check("fiq_bank", da, 32'hB000_0000 | 32'(i));
    end
  endtask

  // The other exception modes keep private 13 and 14; 12 is shared.
  task automatic t_modes();
    for (int m = 2; m < 6; m++) begin
      md(3'(m), 1'b0);
      w(4'hD, 32'hD000_0000 | 32'(m));
      w(4'hE, 32'hE000_0000 | 32'(m));
      w(4'hC, 32'hF000_0000 | 32'(m));
    end
    for (int m = 2; m < 6; m++) begin
      md(3'(m), 1'b0);
      r(4'hD, 4'hE, 1'b0, 1'b0);
      check("mode_stack", da, 32'hD000_0000 | 32'(m));
      check("mode_link", db, 32'hE000_0000 | 32'(m));
      r(4'hC, 4'h8, 1'b0, 1'b0);
      check("shared_r12", da, 32'hF000_0005);
      check("shared_r8", db, 32'hA000_0008);
    end
  endtask

  // Program counter reads: offset per state, or zero when asked.
  task automatic t_pc_read();
    op(6'h04, 4'h0, 2'h0, 32'h0000_1000);
    check("pc_load", pc, 32'h0000_1000);
    r(4'hF, 4'hF, 1'b0, 1'b1);
    check("pc_wide", da, 32'h0000_1000 + bprf_pkg::PC_OFS_WIDE);
    check("pc_zero", db, bprf_pkg::ZERO_WORD);
    md(bprf_pkg::MODE_USER, 1'b1);
    r(4'hF, 4'h3, 1'b0, 1'b0);
    check("pc_compact", da, 32'h0000_1004);
    check("state_keep", db, 32'h0000_00C3);
  endtask

  // Program counter writes of each kind, starting in the compact state.
  task automatic t_pc_write();
    op(6'h20, 4'hF, bprf_pkg::PCW_BRANCH, 32'h0000_2003);
    check("branch_half", pc, 32'h0000_2002);
    check("taken", 32'(branch_taken), 32'h1);
    @(posedge core_clk);
    #1;
    check("taken_pulse", 32'(branch_taken), 32'h0);
    md(bprf_pkg::MODE_USER, 1'b0);
    op(6'h20, 4'hF, bprf_pkg::PCW_BRANCH, 32'h0000_3002);
    check("branch_word", pc, 32'h0000_3000);
    op(6'h20, 4'hF, bprf_pkg::PCW_DISCARD, 32'h0000_4000);
    check("discard_pc", pc, 32'h0000_3000);
    check("discard_nt", 32'(branch_taken), 32'h0);
    op(6'h02, 4'h0, 2'h0, 32'h0000_00D3);
    op(6'h20, 4'hF, bprf_pkg::PCW_FLAGS, 32'hA5F0_0000);
    check("flags", current_status_word, 32'hA000_00D3);
    check("flags_pc", pc, 32'h0000_3000);
  endtask

  // Link writes and exception entry land in the intended bank only.
  task automatic t_link_exc();
    md(bprf_pkg::MODE_IRQ, 1'b0);
    op(6'h08, 4'h0, 2'h0, 32'h0000_5000);
    r(4'hE, 4'h0, 1'b0, 1'b0);
    check("irq_link", da, 32'h0000_5000);
    md(bprf_pkg::MODE_SYSTEM, 1'b0);
    op(6'h10, 4'h3, 2'h0, 32'h0000_6000);
    op(6'h10, 4'h6, 2'h0, 32'h0000_7000);
    r(4'hE, 4'h0, 1'b0, 1'b0);
    check("sys_link", da, 32'hA000_000E);
    md(bprf_pkg::MODE_SVC, 1'b0);
    check("svc_saved", saved_status_word, 32'hA000_00D3);
    check("svc_valid", 32'(saved_valid), 32'h1);
    r(4'hE, 4'h0, 1'b0, 1'b0);
    check("svc_link", da, 32'h0000_6000);
  endtask

  // Saved words exist only outside user and system modes, one per mode.
  task automatic t_saved();
    md(bprf_pkg::MODE_ABT, 1'b0);
    op(6'h01, 4'h0, 2'h0, 32'h2222_2222);
    check("abt_saved", saved_status_word, 32'h2222_2222);
    md(bprf_pkg::MODE_USER, 1'b0);
    op(6'h01, 4'h0, 2'h0, 32'h1111_1111);
    check("usr_saved", saved_status_word, 32'h0000_0000);
    check("usr_valid", 32'(saved_valid), 32'h0);
    md(bprf_pkg::MODE_SYSTEM, 1'b0);
    check("sys_valid", 32'(saved_valid), 32'h0);
    // The spare mode code falls back to the user bank.
    md(3'h7, 1'b0);
    check("m7_valid", 32'(saved_valid), 32'h0);
    r(4'hE, 4'h0, 1'b0, 1'b0);
    check("m7_link", da, 32'hA000_000E);
    md(bprf_pkg::MODE_ABT, 1'b0);
    check("abt_keep", saved_status_word, 32'h2222_2222);
  endtask

  // Reset for ten cycles, then run each scenario once.
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    t_reset();
    t_fiq();
    t_modes();
    t_pc_read();
    t_pc_write();
    t_link_exc();
    t_saved();
    test_done();
  end
endmodule
`default_nettype wire
